// File: hdl/mcp_defs.vh
`ifndef MCP_DEFS_VH
`define MCP_DEFS_VH

// register data and address widths
`define MCP_DATA_W        24
`define MCP_ADDR_W        5
`define MCP_PAGE_W        7

// page numbers
`define MCP_PAGE_MAIN     7'h00
`define MCP_PAGE_CAL      7'h01

// page 0 addresses
`define MCP_ADR_CTRL      5'h1c
`define MCP_ADR_HARM_P    5'h1d
`define MCP_ADR_FUND_P    5'h1e
`define MCP_ADR_FUND_Q    5'h1f
`define MCP_ADR_PAGE      5'h1f

// page 1 addresses
`define MCP_ADR_PULSE_W   5'h00
`define MCP_ADR_NOLOAD    5'h01
`define MCP_ADR_TEMP_SCALE_GAIN     5'h02
`define MCP_ADR_TEMP_ZERO_OFFSET      5'h03

// control field positions
`define MCP_CTL_STOP      8
`define MCP_CTL_IRQ_OD    4
`define MCP_CTL_NOCLK     2
`define MCP_CTL_OSCILLATOR_DISABLE     1
`define MCP_CTL_MASK      24'h000116

// reset values
`define MCP_RST_CTRL      24'h000000
`define MCP_RST_PAGE      7'h00
`define MCP_RST_PULSE_W   24'h000001
`define MCP_RST_NOLOAD    24'h000000
`define MCP_RST_TEMP_SCALE_GAIN     24'h2f03c3
`define MCP_RST_TEMP_ZERO_OFFSET      24'hf3d35a

// fixed-point extremes
`define MCP_POS_MAX       24'h7fffff
`define MCP_NEG_MIN       24'h800000

`endif

// File: hdl/mcp_fund_mult.v
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defs.vh"

// multiplies the voltage and current transform bins of the fundamental
// into active and reactive power; two pipeline stages
module mcp_fund_mult (
    // clock and reset
    input  wire                    clk,
    input  wire                    resetn,
    // transform bins, signed fractions
    input  wire                    bin_valid,
    input  wire [`MCP_DATA_W-1:0]  v_re,
    input  wire [`MCP_DATA_W-1:0]  v_im,
    input  wire [`MCP_DATA_W-1:0]  i_re,
    input  wire [`MCP_DATA_W-1:0]  i_im,
    // fundamental power results
    output reg                     pwr_valid,
    output reg  [`MCP_DATA_W-1:0]  fund_p,
    output reg  [`MCP_DATA_W-1:0]  fund_q
);

    ////////////////////////////////////////////////////////////////////
    // saturate a sum of two q1.46 products back to a 24-bit fraction
    function [`MCP_DATA_W-1:0] sat_frac;
        input signed [48:0] s;
        begin
            // q2.46 sum; keep bits 46..23 unless the top bits disagree
            if (s[48:46] == 3'b000 || s[48:46] == 3'b111) begin
                sat_frac = s[46:23];
            end else if (s[48]) begin
                sat_frac = `MCP_NEG_MIN;
            end else begin
                sat_frac = `MCP_POS_MAX;
            end
        end
    endfunction

    // stage one products
    reg signed [47:0] rr_reg;   // v_re * i_re
    reg signed [47:0] ii_reg;   // v_im * i_im
    reg signed [47:0] ir_reg;   // v_im * i_re
    reg signed [47:0] ri_reg;   // v_re * i_im
    reg               st1_reg;  // stage one holds data

    ////////////////////////////////////////////////////////////////////
    // stage one: four signed products
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rr_reg  <= 48'h000000000000;
            ii_reg  <= 48'h000000000000;
            ir_reg  <= 48'h000000000000;
            ri_reg  <= 48'h000000000000;
            st1_reg <= 1'b0;
        end else begin
            st1_reg <= bin_valid;
            if (bin_valid) begin
                rr_reg <= $signed(v_re) * $signed(i_re);
                ii_reg <= $signed(v_im) * $signed(i_im);
                ir_reg <= $signed(v_im) * $signed(i_re);
                ri_reg <= $signed(v_re) * $signed(i_im);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stage two: real part gives active, imaginary part reactive power
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fund_p    <= 24'h000000;
            fund_q    <= 24'h000000;
            pwr_valid <= 1'b0;
        end else begin
            pwr_valid <= st1_reg;
            if (st1_reg) begin
                fund_p <= sat_frac({rr_reg[47], rr_reg}
                                   + {ii_reg[47], ii_reg});
                fund_q <= sat_frac({ir_reg[47], ir_reg}
                                   - {ri_reg[47], ri_reg});
            end
        end
    end

endmodule
`default_nettype wire

// File: hdl/mcp_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defs.vh"

// control page and calibration page registers of the metering core,
// with the logic those registers steer
module mcp_regs (
    // clock and reset
    input  wire                    clk,
    input  wire                    resetn,
    // word-level register port from the serial port framer
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    input  wire [`MCP_ADDR_W-1:0]  reg_addr,
    input  wire [`MCP_DATA_W-1:0]  reg_wdata,
    output reg  [`MCP_DATA_W-1:0]  reg_rdata,
    output reg                     reg_rvalid,
    output reg  [`MCP_PAGE_W-1:0]  page_sel,
    // measurement datapath inputs
    input  wire                    bin_valid,
    input  wire [`MCP_DATA_W-1:0]  v_re,
    input  wire [`MCP_DATA_W-1:0]  v_im,
    input  wire [`MCP_DATA_W-1:0]  i_re,
    input  wire [`MCP_DATA_W-1:0]  i_im,
    input  wire [`MCP_DATA_W-1:0]  active_power_result,
    input  wire                    word_tick,
    input  wire                    energy_pulse_req,
    input  wire                    temp_valid,
    input  wire [`MCP_DATA_W-1:0]  temp_raw,
    // temperature result, q8.16 signed
    output reg  [`MCP_DATA_W-1:0]  temp_result,
    output reg                     temp_rvalid,
    // energy pulse output
    output reg                     energy_pulse,
    // interrupt pin, active low
    input  wire                    irq_req,
    output reg                     irq_n_out,
    output reg                     irq_n_oe,
    // power management and boot
    output reg                     autoboot_stop,
    output reg                     oscillator_disable,
    output reg                     host_clock_output
);

    ////////////////////////////////////////////////////////////////////
    // true when the access hits a given page and address
    function hit;
        input [`MCP_PAGE_W-1:0] pg;
        input [`MCP_ADDR_W-1:0] ad;
        input [`MCP_PAGE_W-1:0] want_pg;
        input [`MCP_ADDR_W-1:0] want_ad;
        begin
            hit = (pg == want_pg) && (ad == want_ad);
        end
    endfunction

    // reset value of a calibration register by index
    function [`MCP_DATA_W-1:0] cal_rst;
        input [1:0] idx;
        begin
            case (idx)
                2'd0:    cal_rst = `MCP_RST_PULSE_W;
                2'd1:    cal_rst = `MCP_RST_NOLOAD;
                2'd2:    cal_rst = `MCP_RST_TEMP_SCALE_GAIN;
                default: cal_rst = `MCP_RST_TEMP_ZERO_OFFSET;
            endcase
        end
    endfunction

    // control register and page one array
    reg  [`MCP_DATA_W-1:0] device_control_reg;   // control bits only
    reg  [`MCP_DATA_W-1:0] cal_reg [0:3];       // page one registers
    wire [`MCP_DATA_W-1:0] energy_pulse_duration;
    wire [`MCP_DATA_W-1:0] no_load_threshold;
    wire [`MCP_DATA_W-1:0] temp_scale_gain;
    wire [`MCP_DATA_W-1:0] temp_zero_offset;

    // result registers
    reg  [`MCP_DATA_W-1:0] harmonic_active_power_reg;
    wire [`MCP_DATA_W-1:0] fundamental_active_power;
    wire [`MCP_DATA_W-1:0] fundamental_reactive_power;
    wire                   fund_valid;

    assign energy_pulse_duration = cal_reg[0];
    assign no_load_threshold     = cal_reg[1];
    assign temp_scale_gain       = cal_reg[2];
    assign temp_zero_offset      = cal_reg[3];

    ////////////////////////////////////////////////////////////////////
    // fundamental power multiplier
    mcp_fund_mult u_fund (
        .clk       (clk),
        .resetn    (resetn),
        .bin_valid (bin_valid),
        .v_re      (v_re),
        .v_im      (v_im),
        .i_re      (i_re),
        .i_im      (i_im),
        .pwr_valid (fund_valid),
        .fund_p    (fundamental_active_power),
        .fund_q    (fundamental_reactive_power)
    );

    ////////////////////////////////////////////////////////////////////
    // page select: any write to address 31 lands here, never on the
    // reactive result, so the page is reachable from every page
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            page_sel <= `MCP_RST_PAGE;
        end else if (reg_wr && reg_addr == `MCP_ADR_PAGE) begin
            page_sel <= reg_wdata[`MCP_PAGE_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register: unused bits are never stored
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            device_control_reg <= `MCP_RST_CTRL;
        end else if (reg_wr && hit(page_sel, reg_addr, `MCP_PAGE_MAIN,
                                   `MCP_ADR_CTRL)) begin
            device_control_reg <= reg_wdata & `MCP_CTL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // page one registers, one slice per address
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_cal
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cal_reg[g] <= cal_rst(g[1:0]);
                end else if (reg_wr && hit(page_sel, reg_addr,
                                           `MCP_PAGE_CAL,
                                           g[`MCP_ADDR_W-1:0])) begin
                    cal_reg[g] <= reg_wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // harmonic power: total minus fundamental, saturated to a fraction
    wire [`MCP_DATA_W:0] harm_diff;
    assign harm_diff = {active_power_result[`MCP_DATA_W-1],
                        active_power_result}
                     - {fundamental_active_power[`MCP_DATA_W-1],
                        fundamental_active_power};

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            harmonic_active_power_reg <= 24'h000000;
        end else if (fund_valid) begin
            // overflow shows as disagreeing top bits
            if (harm_diff[24] == harm_diff[23]) begin
                harmonic_active_power_reg <= harm_diff[23:0];
            end else if (harm_diff[24]) begin
                harmonic_active_power_reg <= `MCP_NEG_MIN;
            end else begin
                harmonic_active_power_reg <= `MCP_POS_MAX;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read as zero
    reg [`MCP_DATA_W-1:0] rd_mux;

    always @* begin
        rd_mux = 24'h000000;
        if (page_sel == `MCP_PAGE_MAIN) begin
            case (reg_addr)
                `MCP_ADR_CTRL:   rd_mux = device_control_reg;
                `MCP_ADR_HARM_P: rd_mux = harmonic_active_power_reg;
                `MCP_ADR_FUND_P: rd_mux = fundamental_active_power;
                `MCP_ADR_FUND_Q: rd_mux = fundamental_reactive_power;
                default:         rd_mux = 24'h000000;
            endcase
        end else if (page_sel == `MCP_PAGE_CAL && reg_addr[4:2] == 3'b000)
        begin
            rd_mux = cal_reg[reg_addr[1:0]];
        end
    end

    // read data is captured on the strobe edge and shown with valid one cycle after
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata  <= 24'h000000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // energy pulse: width counted in word-rate ticks; a request is
    // dropped while a pulse is running or the load is below threshold
    reg  [`MCP_DATA_W-1:0] pulse_cnt_reg;
    wire [`MCP_DATA_W-1:0] p_mag;
    wire                   below_load;

    // magnitude of the most negative value is clipped to full scale
    assign p_mag = active_power_result[23]
                 ? ((active_power_result == `MCP_NEG_MIN) ? `MCP_POS_MAX
                    : (24'h000000 - active_power_result))
                 : active_power_result;
    // threshold treated as non-negative as the host is told to keep it
    assign below_load = p_mag < no_load_threshold;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt_reg <= 24'h000000;
            energy_pulse  <= 1'b0;
        end else if (energy_pulse) begin
            if (word_tick) begin
                if (pulse_cnt_reg <= 24'h000001) begin
                    energy_pulse  <= 1'b0;
                    pulse_cnt_reg <= 24'h000000;
                end else begin
                    pulse_cnt_reg <= pulse_cnt_reg - 24'h000001;
                end
            end
        end else if (energy_pulse_req && !below_load) begin
            energy_pulse  <= 1'b1;
            // a zero width is outside the host range; treat it as one
            pulse_cnt_reg <= (energy_pulse_duration == 24'h000000)
                           ? 24'h000001 : energy_pulse_duration;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // temperature: (raw + offset) * gain, raw and offset q1.23,
    // gain q7.17 unsigned, result q8.16 signed with saturation
    wire signed [24:0] t_sum;
    wire signed [49:0] t_prod;

    assign t_sum  = $signed({temp_raw[23], temp_raw})
                  + $signed({temp_zero_offset[23], temp_zero_offset});
    assign t_prod = t_sum * $signed({1'b0, temp_scale_gain});

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temp_result <= 24'h000000;
            temp_rvalid <= 1'b0;
        end else begin
            temp_rvalid <= temp_valid;
            if (temp_valid) begin
                // q9.40 product; bits 47..24 form q8.16
                if (t_prod[49:47] == 3'b000 || t_prod[49:47] == 3'b111)
                begin
                    temp_result <= t_prod[47:24];
                end else if (t_prod[49]) begin
                    temp_result <= `MCP_NEG_MIN;
                end else begin
                    temp_result <= `MCP_POS_MAX;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt pin and control-driven outputs, all registered
    reg host_clk_div_reg;   // free divider, halves clk

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_n_out          <= 1'b1;
            irq_n_oe           <= 1'b1;
            autoboot_stop      <= 1'b0;
            oscillator_disable <= 1'b0;
            host_clock_output  <= 1'b0;
            host_clk_div_reg   <= 1'b0;
        end else begin
            host_clk_div_reg <= ~host_clk_div_reg;
            // open drain: only pull low, release otherwise
            if (device_control_reg[`MCP_CTL_IRQ_OD]) begin
                irq_n_out <= 1'b0;
                irq_n_oe  <= irq_req;
            end else begin
                irq_n_out <= ~irq_req;
                irq_n_oe  <= 1'b1;
            end
            // stop and oscillator levels mirror control bits
            autoboot_stop      <= device_control_reg[`MCP_CTL_STOP];
            oscillator_disable <= device_control_reg[`MCP_CTL_OSCILLATOR_DISABLE];
            // a stopped host clock parks low to avoid a runt edge
            if (device_control_reg[`MCP_CTL_NOCLK]) begin
                host_clock_output <= 1'b0;
            end else begin
                host_clock_output <= host_clk_div_reg;
            end
        end
    end
    // oscillator_disable follows control bit 1
    // autoboot_stop follows control bit 8

endmodule
`default_nettype wire

// File: test/mcp_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defs.vh"

// port checks for the register bank; it shadows the few registers the
// checks need from write traffic, so it never peeks inside the design
module mcp_regs_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [4:0]  reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic [6:0]  page_sel,
    // energy pulse path
    input wire logic [23:0] active_power_result,
    input wire logic        word_tick,
    input wire logic        energy_pulse_req,
    input wire logic        energy_pulse,
    // steered levels
    input wire logic        autoboot_stop,
    input wire logic        oscillator_disable,
    input wire logic        host_clock_output
);
    logic [23:0] ctl_sh;  // control word as written
    logic [23:0] pw_sh;   // pulse width as written
    logic [23:0] thr_sh;  // no-load threshold as written
    logic [23:0] tk_cnt;  // ticks seen while the pulse is high
    logic [1:0]  up_cnt;  // edges since reset, saturates at 3
    logic [23:0] p_mag;   // magnitude of the active power
    logic [23:0] pw_eff;  // a zero width acts as one

    assign p_mag  = active_power_result[23] ? -active_power_result
                                            : active_power_result;
    assign pw_eff = (pw_sh == 24'h0) ? 24'h1 : pw_sh;

    ////////////////////////////////////////////////////////////////////
    // shadows use the page that is selected at the strobe edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_sh <= `MCP_RST_CTRL;
            pw_sh  <= `MCP_RST_PULSE_W;
            thr_sh <= `MCP_RST_NOLOAD;
            tk_cnt <= 24'h0;
            up_cnt <= 2'h0;
        end else begin
            if (reg_wr && page_sel == 7'h00 && reg_addr == 5'h1c)
                ctl_sh <= reg_wdata;
            if (reg_wr && page_sel == 7'h01 && reg_addr == 5'h00)
                pw_sh <= reg_wdata;
            if (reg_wr && page_sel == 7'h01 && reg_addr == 5'h01)
                thr_sh <= reg_wdata;
            // counting restarts whenever the pulse is low
            tk_cnt <= !energy_pulse ? 24'h0 : tk_cnt + {23'h0, word_tick};
            if (up_cnt != 2'h3)
                up_cnt <= up_cnt + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_stop_follows: assert property (
        autoboot_stop == $past(ctl_sh[8]))
        else $error("stop level differs from control word");
    a_osc_follows: assert property (
        oscillator_disable == $past(ctl_sh[1]))
        else $error("oscillator level differs from control word");
    a_clk_parked: assert property (
        $past(ctl_sh[2]) |-> !host_clock_output)
        else $error("host clock runs while disabled");
    a_clk_runs: assert property (
        (up_cnt == 2'h3 && !$past(ctl_sh[2]) && !$past(ctl_sh[2], 2))
        |-> host_clock_output != $past(host_clock_output))
        else $error("host clock stalled while enabled");
    a_page_write: assert property (
        reg_wr && reg_addr == 5'h1f |=> page_sel == $past(reg_wdata[6:0]))
        else $error("page select missed a write");
    a_page_hold: assert property (
        !(reg_wr && reg_addr == 5'h1f) |=> $stable(page_sel))
        else $error("page select moved without a write");
    a_read_valid: assert property (
        reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read");
    a_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_pulse_cause: assert property (
        $rose(energy_pulse) |-> $past(energy_pulse_req)
        && $past(p_mag) >= $past(thr_sh))
        else $error("pulse without request above threshold");
    a_pulse_long: assert property (
        $fell(energy_pulse) |-> tk_cnt == pw_eff)
        else $error("pulse ended at the wrong tick");
    a_pulse_short: assert property (
        energy_pulse |-> tk_cnt < pw_eff)
        else $error("pulse outlived its width");
endmodule

bind mcp_regs mcp_regs_monitor mon (
    .clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .page_sel, .active_power_result, .word_tick,
    .energy_pulse_req, .energy_pulse, .autoboot_stop,
    .oscillator_disable, .host_clock_output);
`default_nettype wire

// File: test/mcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the register port; strobes launch at a falling edge and
// live one cycle, and released lines carry junk rather than old values
module mcp_host_model (
    // clock
    input wire logic        clk,
    // register port toward the device
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [4:0]      reg_addr,
    output logic [23:0]     reg_wdata,
    input wire logic [23:0] reg_rdata,
    input wire logic        reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h0;
        reg_wdata = 24'h0;
    end

    // one word written to the selected page
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // one word read; valid and data are taken in the answer cycle
    task automatic rd(input logic [4:0] a, output logic [23:0] d,
                      output logic ok);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask

    // width is clamped into its legal range before it is sent
    task automatic set_width(input logic [23:0] w);
        wr(5'h00, (w == 24'h0) ? 24'h1 : w[23] ? 24'h7fffff : w);
    endtask

    // a negative threshold is never sent
    task automatic set_thr(input logic [23:0] t);
        wr(5'h01, {1'b0, t[22:0]});
    endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// host model on the register port; the bench plays the datapath
module tb_top;
    logic        clk, resetn, reg_wr, reg_rd, reg_rvalid;  // control
    logic [4:0]  reg_addr;                                 // word address
    logic [23:0] reg_wdata, reg_rdata, temp_result;        // data words
    logic [6:0]  page_sel;                                 // page
    logic        bin_valid, word_tick, energy_pulse_req, temp_valid;
    logic [23:0] v_re, v_im, i_re, i_im, active_power_result, temp_raw;
    logic        temp_rvalid, energy_pulse, irq_req, irq_n_out, irq_n_oe;
    logic        autoboot_stop, oscillator_disable, host_clock_output;
    int          fail_count, samples_checked;              // tallies

    mcp_regs dut (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .page_sel, .bin_valid, .v_re, .v_im,
        .i_re, .i_im, .active_power_result, .word_tick, .energy_pulse_req,
        .temp_valid, .temp_raw, .temp_result, .temp_rvalid, .energy_pulse,
        .irq_req, .irq_n_out, .irq_n_oe, .autoboot_stop,
        .oscillator_disable, .host_clock_output);
    mcp_host_model host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid);

    // 10 MHz
    always #50 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // a missing valid is turned into a mismatch
    task automatic rdchk(input logic [4:0] a, input logic [23:0] e);
        logic [23:0] d;
        logic        ok;
        host.rd(a, d, ok);
        chk(ok === 1'b1 ? d : ~e, e);
    endtask

    task automatic t_regs;
        rdchk(5'h1c, 24'h000000);
        chk({17'h0, page_sel}, 24'h0);
        host.wr(5'h1f, 24'h000001);
        chk({17'h0, page_sel}, 24'h1);
        rdchk(5'h00, 24'h000001);
        rdchk(5'h01, 24'h000000);
        rdchk(5'h02, 24'h2f03c3);
        rdchk(5'h03, 24'hf3d35a);
        host.wr(5'h05, 24'h123456);
        rdchk(5'h05, 24'h000000);
        rdchk(5'h1f, 24'h000000);
        host.wr(5'h02, 24'hffffff);
        rdchk(5'h02, 24'hffffff);
        chk({17'h0, page_sel}, 24'h1);
    endtask

    // both settings of every control bit, interrupt request both ways
    task automatic t_ctrl;
        logic h0;
        logic h1;
        host.wr(5'h1f, 24'h000000);
        for (int m = 0; m < 2; m++) begin
            host.wr(5'h1c, m ? 24'hffffff : 24'h000000);
            rdchk(5'h1c, m ? 24'h000116 : 24'h000000);
            chk({22'h0, autoboot_stop, oscillator_disable},
                m ? 24'h3 : 24'h0);
            h0 = host_clock_output;
            cyc(1);
            h1 = host_clock_output;
            chk({22'h0, h0 | h1, h0 ^ h1}, m ? 24'h0 : 24'h3);
            for (int r = 0; r < 2; r++) begin
                irq_req = r[0];
                cyc(2);
                chk({22'h0, irq_n_out, irq_n_oe},
                    {22'h0, ~(r[0] | m[0]), m ? r[0] : 1'b1});
            end
        end
        irq_req = 1'b0;
    endtask

    // the imaginary voltage bin makes the reactive result non-zero
    task automatic t_fund;
        active_power_result = 24'h100000;
        v_re = 24'h400000;
        v_im = 24'h400000;
        i_re = 24'h400000;
        bin_valid = 1'b1;
        cyc(1);
        bin_valid = 1'b0;
        cyc(4);
        rdchk(5'h1e, 24'h200000);
        rdchk(5'h1f, 24'h200000);
        rdchk(5'h1d, 24'hf00000);
        host.wr(5'h1f, 24'hffff80);
        chk({17'h0, page_sel}, 24'h0);
        rdchk(5'h1e, 24'h200000);
        rdchk(5'h1f, 24'h200000);
    endtask

    task automatic pulse_req(input logic e);
        energy_pulse_req = 1'b1;
        cyc(1);
        energy_pulse_req = 1'b0;
        chk({23'h0, energy_pulse}, {23'h0, e});
    endtask

    task automatic t_pulse;
        host.wr(5'h1f, 24'h000001);
        host.set_width(24'h000003);
        host.set_thr(24'h100000);
        rdchk(5'h01, 24'h100000);
        active_power_result = 24'h080000;
        pulse_req(1'b0);
        active_power_result = 24'he00000;
        pulse_req(1'b1);
        for (int i = 0; i < 3; i++) begin
            word_tick = 1'b1;
            cyc(1);
            word_tick = 1'b0;
            chk({23'h0, energy_pulse}, {23'h0, i < 2});
            cyc(1);
        end
    endtask

    task automatic temp_chk(input logic [23:0] raw, input logic [23:0] e);
        temp_raw = raw;
        temp_valid = 1'b1;
        cyc(1);
        temp_valid = 1'b0;
        chk(temp_rvalid === 1'b1 ? temp_result : ~e, e);
    endtask

    task automatic t_temp;
        host.wr(5'h02, 24'h2f03c3);
        temp_chk(24'h0c2ca6, 24'h000000);
        temp_chk(24'h4c2ca6, 24'h0bc0f0);
        host.wr(5'h03, 24'h000000);
        host.wr(5'h02, 24'h800000);
        temp_chk(24'h000400, 24'h000200);
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        {bin_valid, word_tick, energy_pulse_req, temp_valid, irq_req} = '0;
        {v_re, v_im, i_re, i_im, active_power_result, temp_raw} = '0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        t_regs;
        t_ctrl;
        t_fund;
        t_pulse;
        t_temp;
        report_and_stop;
    end
endmodule
`default_nettype wire
